/* File: include/ua_pkg.sv */
// Summary of operation
// RL1: Writing one to modem control bit 0 drives the channel's terminal-ready output low.
// RL2: Terminal-ready returns high on writing zero to that bit, and after reset.
// RL3: Writing one to modem control bit 1 drives the request-to-send output low.
// RL4: Request-to-send is high after reset.
// RL5: Handshake outputs are software levels only; they never affect transmit or receive.
// RL6: A rising edge on the ring input raises an interrupt for that channel.
// RL7: Serial output is high during reset, when idle, and when the transmitter is off.
// RL8: The remote device keeps the receive line high in reset, idle or disabled.
// RL9: In loop-back the receive pin is ignored and transmit data feeds the receiver.
// RL10: In loop-back the serial output pin is cut off from the transmitter.
// RL11: Every transmitted character gets a start bit before and stop bits after.
// RL12: With parity on, a parity bit is sent and checked on receive.
// RL13: Each channel has a 16-entry byte buffer per direction.
// RL14: Four selectable receive fill thresholds raise a receive interrupt.
// RL15: Only a selected channel is reached; address bit picks channel A or B.
// RL16: Write direction stores data in the addressed register; read direction returns it.
// RL17: Divisor registers replace the low offsets while line control bit 7 is set.
// RL18: Each channel keeps independent control bits, buffers and modem signals.
package ua_pkg;
  localparam logic [7:0] UA_OFF_STAT = 8'h80;
  localparam logic [7:0] UA_OFF_MASK = 8'h84;
  localparam logic [2:0] UA_R_DATA = 3'h0;
  localparam logic [2:0] UA_R_IER = 3'h1;
  localparam logic [2:0] UA_R_ISR = 3'h2;
  localparam logic [2:0] UA_R_LCR = 3'h3;
  localparam logic [2:0] UA_R_MCR = 3'h4;
  localparam logic [2:0] UA_R_LSR = 3'h5;
  localparam logic [2:0] UA_R_MSR = 3'h6;
  localparam logic [2:0] UA_R_SPR = 3'h7;
  localparam int UA_MCR_DTR = 0;
  localparam int UA_MCR_RTS = 1;
  localparam int UA_MCR_LOOP = 4;
  localparam int UA_LCR_STB = 2;
  localparam int UA_LCR_PEN = 3;
  localparam int UA_LCR_EPS = 4;
  localparam int UA_LCR_DLAB = 7;
  localparam int UA_FCR_RXCLR = 1;
  localparam int UA_FCR_TXCLR = 2;
  localparam logic [7:0] UA_LCR_RST = 8'h03;
  localparam logic [7:0] UA_DLL_RST = 8'h01;
  localparam logic [4:0] UA_TRIG0 = 5'h01;
  localparam logic [4:0] UA_TRIG1 = 5'h04;
  localparam logic [4:0] UA_TRIG2 = 5'h08;
  localparam logic [4:0] UA_TRIG3 = 5'h0E;
  localparam logic [1:0] UA_RESP_OK = 2'h0;
  localparam logic [1:0] UA_RESP_ERR = 2'h2;
  typedef enum logic [2:0] {UA_IDLE, UA_START, UA_DATA, UA_PAR, UA_STOP} ua_ser_state_type;
endpackage

/* File: rtl/ua_top.sv */
`timescale 1ns/10ps
module ua_top #(
  parameter int FIFO_DEPTH = 16
)(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic serial_in_a,
  input wire logic serial_in_b,
  input wire logic ring_in_a_n,
  input wire logic ring_in_b_n,
  output logic serial_out_a,
  output logic serial_out_b,
  output logic dtr_a_n,
  output logic dtr_b_n,
  output logic rts_a_n,
  output logic rts_b_n,
  output logic irq
);
  localparam int AW = $clog2(FIFO_DEPTH);

  function automatic logic ua_chan_hit(input logic [7:0] a);
    return a[7:6] == 2'b00;
  endfunction

  logic awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff, ws_ff, irq_ff;
  logic [1:0] bresp_ff, rresp_ff;
  logic [31:0] rdata_ff, rd_val;
  logic [7:0] aw_ff, wd_ff;
  logic [5:0] stat_ff, mask_ff, ch_set, nxt_clr;
  logic rd_err, wr_go, rd_go;
  logic [1:0] wr_ch, rx_pop, ch_pin, ch_dtr_n, ch_rts_n;
  logic [7:0] ch_lcr [2];
  logic [7:0] ch_mcr [2];
  logic [7:0] ch_spr [2];
  logic [7:0] ch_dll [2];
  logic [7:0] ch_dlm [2];
  logic [7:0] ch_lsr [2];
  logic [7:0] ch_rxd [2];
  logic [1:0] sin_w, ring_w;

  assign sin_w = {serial_in_b, serial_in_a};
  assign ring_w = {ring_in_b_n, ring_in_a_n};
  assign wr_go = !awready_ff && !wready_ff && !bvalid_ff;
  assign rd_go = s_axi_arvalid && arready_ff;

  // Write address and data are taken independently; the write acts once both are held.
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      awready_ff <= 1'b1;
      wready_ff <= 1'b1;
      bvalid_ff <= 1'b0;
      bresp_ff <= ua_pkg::UA_RESP_OK;
      aw_ff <= 8'h00;
      wd_ff <= 8'h00;
      ws_ff <= 1'b0;
    end
    else
    begin
      if (s_axi_awvalid && awready_ff)
      begin
        aw_ff <= s_axi_awaddr;
        awready_ff <= 1'b0;
      end
      if (s_axi_wvalid && wready_ff)
      begin
        wd_ff <= s_axi_wdata[7:0];
        ws_ff <= s_axi_wstrb[0];
        wready_ff <= 1'b0;
      end
      if (wr_go)
      begin
        bvalid_ff <= 1'b1;
        bresp_ff <= (ua_chan_hit(aw_ff) || aw_ff == ua_pkg::UA_OFF_STAT
                     || aw_ff == ua_pkg::UA_OFF_MASK) ? ua_pkg::UA_RESP_OK : ua_pkg::UA_RESP_ERR;
      end
      else if (bvalid_ff && s_axi_bready)
      begin
        bvalid_ff <= 1'b0;
        awready_ff <= 1'b1;
        wready_ff <= 1'b1;
      end
    end
  end

  always_comb
  begin
    rd_val = 32'h0000_0000;
    rd_err = 1'b0;
    if (ua_chan_hit(s_axi_araddr)) // RL15
    begin
      case (s_axi_araddr[4:2]) // RL16
        ua_pkg::UA_R_DATA: rd_val[7:0] = ch_lcr[s_axi_araddr[5]][ua_pkg::UA_LCR_DLAB]
                             ? ch_dll[s_axi_araddr[5]] : ch_rxd[s_axi_araddr[5]]; // RL17
        ua_pkg::UA_R_IER: rd_val[7:0] = ch_lcr[s_axi_araddr[5]][ua_pkg::UA_LCR_DLAB]
                            ? ch_dlm[s_axi_araddr[5]] : 8'h00;
        ua_pkg::UA_R_ISR: rd_val[2:0] = s_axi_araddr[5] ? stat_ff[5:3] : stat_ff[2:0];
        ua_pkg::UA_R_LCR: rd_val[7:0] = ch_lcr[s_axi_araddr[5]];
        ua_pkg::UA_R_MCR: rd_val[7:0] = ch_mcr[s_axi_araddr[5]];
        ua_pkg::UA_R_LSR: rd_val[7:0] = ch_lsr[s_axi_araddr[5]];
        ua_pkg::UA_R_MSR: rd_val[6] = !ring_w[s_axi_araddr[5]];
        ua_pkg::UA_R_SPR: rd_val[7:0] = ch_spr[s_axi_araddr[5]];
        default: rd_val = 32'h0000_0000;
      endcase
    end
    else if (s_axi_araddr == ua_pkg::UA_OFF_STAT)
      rd_val[5:0] = stat_ff;
    else if (s_axi_araddr == ua_pkg::UA_OFF_MASK)
      rd_val[5:0] = mask_ff;
    else
      rd_err = 1'b1;
  end

  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      arready_ff <= 1'b1;
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      rresp_ff <= ua_pkg::UA_RESP_OK;
    end
    else if (rd_go)
    begin
      arready_ff <= 1'b0;
      rvalid_ff <= 1'b1;
      rdata_ff <= rd_val;
      rresp_ff <= rd_err ? ua_pkg::UA_RESP_ERR : ua_pkg::UA_RESP_OK;
    end
    else if (rvalid_ff && s_axi_rready)
    begin
      rvalid_ff <= 1'b0;
      arready_ff <= 1'b1;
    end
  end

  // Sticky status: a set in the same cycle as its clear wins.
  assign nxt_clr = (wr_go && ws_ff && aw_ff == ua_pkg::UA_OFF_STAT) ? wd_ff[5:0] : 6'h00;
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      stat_ff <= 6'h00;
      mask_ff <= 6'h00;
      irq_ff <= 1'b0;
    end
    else
    begin
      stat_ff <= (stat_ff & ~nxt_clr) | ch_set;
      if (wr_go && ws_ff && aw_ff == ua_pkg::UA_OFF_MASK)
        mask_ff <= wd_ff[5:0];
      irq_ff <= |(stat_ff & mask_ff);
    end
  end

  for (genvar c = 0; c < 2; c++)
  begin : g_ch
    logic [7:0] lcr_ff, mcr_ff, spr_ff, dll_ff, dlm_ff, tsh_ff, rsh_ff, dmask, rx_al;
    logic [1:0] trig_ff;
    logic dtr_n_ff, rts_n_ff, pin_ff, txd_ff, tpar_ff, stop2_ff, perr_ff, ring_q_ff;
    logic [7:0] txm [FIFO_DEPTH];
    logic [8:0] rxm [FIFO_DEPTH];
    logic [AW-1:0] twp_ff, trp_ff, rwp_ff, rrp_ff;
    logic [AW:0] tcnt_ff, rcnt_ff;
    logic [15:0] div, tb_ff, rb_ff;
    logic [2:0] tn_ff, rn_ff, last;
    logic [4:0] trig_lvl;
    ua_pkg::ua_ser_state_type tst_ff, rst_ff;
    logic wr, dlab, tpush, tpop, rpush, rxl;

    assign wr = wr_ch[c];
    assign dlab = lcr_ff[ua_pkg::UA_LCR_DLAB];
    assign div = ({dlm_ff, dll_ff} == 16'h0000) ? 16'h0001 : {dlm_ff, dll_ff};
    assign last = {1'b1, lcr_ff[1:0]};
    assign dmask = 8'hFF >> (2'h3 - lcr_ff[1:0]);
    assign rx_al = rsh_ff >> (2'h3 - lcr_ff[1:0]);
    assign tpush = wr && aw_ff[4:2] == ua_pkg::UA_R_DATA && !dlab
                   && tcnt_ff != (AW+1)'(FIFO_DEPTH); // RL13
    assign tpop = tst_ff == ua_pkg::UA_IDLE && tcnt_ff != '0;
    assign rpush = rst_ff == ua_pkg::UA_STOP && rb_ff == 16'h0000
                   && rcnt_ff != (AW+1)'(FIFO_DEPTH); // RL13
    assign rxl = mcr_ff[ua_pkg::UA_MCR_LOOP] ? txd_ff : sin_w[c]; // RL9
    assign wr_ch[c] = wr_go && ws_ff && ua_chan_hit(aw_ff) && aw_ff[5] == 1'(c); // RL15 RL18
    assign rx_pop[c] = rd_go && ua_chan_hit(s_axi_araddr) && s_axi_araddr[5] == 1'(c)
                       && s_axi_araddr[4:2] == ua_pkg::UA_R_DATA && !dlab;
    always_comb
    begin
      case (trig_ff) // RL14
        2'h0: trig_lvl = ua_pkg::UA_TRIG0;
        2'h1: trig_lvl = ua_pkg::UA_TRIG1;
        2'h2: trig_lvl = ua_pkg::UA_TRIG2;
        default: trig_lvl = ua_pkg::UA_TRIG3;
      endcase
    end
    assign ch_set[3*c] = ring_w[c] && !ring_q_ff; // RL6
    assign ch_set[3*c+1] = 5'(rcnt_ff) >= trig_lvl; // RL14
    assign ch_set[3*c+2] = rpush && perr_ff; // RL12
    assign ch_lcr[c] = lcr_ff;
    assign ch_mcr[c] = mcr_ff;
    assign ch_spr[c] = spr_ff;
    assign ch_dll[c] = dll_ff;
    assign ch_dlm[c] = dlm_ff;
    assign ch_rxd[c] = rxm[rrp_ff][7:0];
    assign ch_lsr[c] = {1'b0, tcnt_ff == '0 && tst_ff == ua_pkg::UA_IDLE, tcnt_ff == '0,
                        2'b00, rcnt_ff != '0 && rxm[rrp_ff][8], 1'b0, rcnt_ff != '0};
    assign ch_pin[c] = pin_ff;
    assign ch_dtr_n[c] = dtr_n_ff;
    assign ch_rts_n[c] = rts_n_ff;

    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
      if (sys_rst)
      begin
        lcr_ff <= ua_pkg::UA_LCR_RST;
        mcr_ff <= 8'h00;
        spr_ff <= 8'h00;
        dll_ff <= ua_pkg::UA_DLL_RST;
        dlm_ff <= 8'h00;
        trig_ff <= 2'h0;
        dtr_n_ff <= 1'b1; // RL2
        rts_n_ff <= 1'b1; // RL4
        ring_q_ff <= 1'b1;
      end
      else
      begin
        ring_q_ff <= ring_w[c];
        if (wr)
        begin
          case (aw_ff[4:2]) // RL16
            ua_pkg::UA_R_DATA: if (dlab) dll_ff <= wd_ff; // RL17
            ua_pkg::UA_R_IER: if (dlab) dlm_ff <= wd_ff; // RL17
            ua_pkg::UA_R_ISR: trig_ff <= wd_ff[7:6];
            ua_pkg::UA_R_LCR: lcr_ff <= wd_ff;
            ua_pkg::UA_R_MCR:
            begin
              mcr_ff <= wd_ff;
              dtr_n_ff <= !wd_ff[ua_pkg::UA_MCR_DTR]; // RL1 RL2 RL5
              rts_n_ff <= !wd_ff[ua_pkg::UA_MCR_RTS]; // RL3 RL5
            end
            ua_pkg::UA_R_SPR: spr_ff <= wd_ff;
            default: spr_ff <= spr_ff;
          endcase
        end
      end
    end

    always_ff @(posedge clk_sys)
    begin
      if (tpush)
        txm[twp_ff] <= wd_ff;
      if (rpush)
        rxm[rwp_ff] <= {perr_ff, rx_al};
    end

    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
      if (sys_rst)
      begin
        twp_ff <= '0;
        trp_ff <= '0;
        tcnt_ff <= '0;
        rwp_ff <= '0;
        rrp_ff <= '0;
        rcnt_ff <= '0;
      end
      else
      begin
        if (wr && aw_ff[4:2] == ua_pkg::UA_R_ISR && wd_ff[ua_pkg::UA_FCR_TXCLR])
        begin
          trp_ff <= twp_ff;
          tcnt_ff <= '0;
        end
        else
        begin
          twp_ff <= twp_ff + AW'(tpush);
          trp_ff <= trp_ff + AW'(tpop);
          tcnt_ff <= tcnt_ff + (AW+1)'(tpush) - (AW+1)'(tpop);
        end
        if (wr && aw_ff[4:2] == ua_pkg::UA_R_ISR && wd_ff[ua_pkg::UA_FCR_RXCLR])
        begin
          rrp_ff <= rwp_ff;
          rcnt_ff <= '0;
        end
        else
        begin
          rwp_ff <= rwp_ff + AW'(rpush);
          rrp_ff <= rrp_ff + AW'(rx_pop[c] && rcnt_ff != '0);
          rcnt_ff <= rcnt_ff + (AW+1)'(rpush) - (AW+1)'(rx_pop[c] && rcnt_ff != '0);
        end
      end
    end

    // Transmitter: one bit per divisor count of system clocks.
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
      if (sys_rst)
      begin
        tst_ff <= ua_pkg::UA_IDLE;
        txd_ff <= 1'b1; // RL7
        pin_ff <= 1'b1; // RL7
        tb_ff <= 16'h0000;
        tsh_ff <= 8'h00;
        tn_ff <= 3'h0;
        tpar_ff <= 1'b0;
        stop2_ff <= 1'b0;
      end
      else
      begin
        pin_ff <= mcr_ff[ua_pkg::UA_MCR_LOOP] ? 1'b1 : txd_ff; // RL10
        if (tst_ff != ua_pkg::UA_IDLE && tb_ff != 16'h0000)
          tb_ff <= tb_ff - 16'h0001;
        else
        begin
          tb_ff <= div - 16'h0001;
          case (tst_ff)
            ua_pkg::UA_IDLE:
            begin
              txd_ff <= !tpop; // RL7 RL11
              if (tpop)
              begin
                tsh_ff <= txm[trp_ff] & dmask;
                tpar_ff <= ^(txm[trp_ff] & dmask) ^ !lcr_ff[ua_pkg::UA_LCR_EPS];
                tst_ff <= ua_pkg::UA_START;
              end
            end
            ua_pkg::UA_START:
            begin
              txd_ff <= tsh_ff[0];
              tn_ff <= 3'h0;
              tst_ff <= ua_pkg::UA_DATA;
            end
            ua_pkg::UA_DATA:
            begin
              if (tn_ff == last)
              begin
                txd_ff <= lcr_ff[ua_pkg::UA_LCR_PEN] ? tpar_ff : 1'b1; // RL12
                stop2_ff <= 1'b0;
                tst_ff <= lcr_ff[ua_pkg::UA_LCR_PEN] ? ua_pkg::UA_PAR : ua_pkg::UA_STOP;
              end
              else
              begin
                txd_ff <= tsh_ff[1];
                tsh_ff <= tsh_ff >> 1;
                tn_ff <= tn_ff + 3'h1;
              end
            end
            ua_pkg::UA_PAR:
            begin
              txd_ff <= 1'b1;
              tst_ff <= ua_pkg::UA_STOP;
            end
            ua_pkg::UA_STOP:
            begin
              stop2_ff <= 1'b1;
              if (!lcr_ff[ua_pkg::UA_LCR_STB] || stop2_ff) // RL11
                tst_ff <= ua_pkg::UA_IDLE;
            end
            default: tst_ff <= ua_pkg::UA_IDLE;
          endcase
        end
      end
    end

    // Receiver: checks the start bit at mid-bit, then samples once per bit.
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
      if (sys_rst)
      begin
        rst_ff <= ua_pkg::UA_IDLE;
        rb_ff <= 16'h0000;
        rsh_ff <= 8'h00;
        rn_ff <= 3'h0;
        perr_ff <= 1'b0;
      end
      else if (rst_ff == ua_pkg::UA_IDLE)
      begin
        perr_ff <= 1'b0;
        rb_ff <= div >> 1;
        if (!rxl)
          rst_ff <= ua_pkg::UA_START;
      end
      else if (rb_ff != 16'h0000)
        rb_ff <= rb_ff - 16'h0001;
      else
      begin
        rb_ff <= div - 16'h0001;
        case (rst_ff)
          ua_pkg::UA_START:
          begin
            rn_ff <= 3'h0;
            rst_ff <= rxl ? ua_pkg::UA_IDLE : ua_pkg::UA_DATA;
          end
          ua_pkg::UA_DATA:
          begin
            rsh_ff <= {rxl, rsh_ff[7:1]};
            rn_ff <= rn_ff + 3'h1;
            if (rn_ff == last)
              rst_ff <= lcr_ff[ua_pkg::UA_LCR_PEN] ? ua_pkg::UA_PAR : ua_pkg::UA_STOP;
          end
          ua_pkg::UA_PAR:
          begin
            perr_ff <= rxl != (^rx_al ^ !lcr_ff[ua_pkg::UA_LCR_EPS]); // RL12
            rst_ff <= ua_pkg::UA_STOP;
          end
          default: rst_ff <= ua_pkg::UA_IDLE;
        endcase
      end
    end
  end

  assign s_axi_awready = awready_ff;
  assign s_axi_wready = wready_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_arready = arready_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;
  assign serial_out_a = ch_pin[0];
  assign serial_out_b = ch_pin[1];
  assign dtr_a_n = ch_dtr_n[0];
  assign dtr_b_n = ch_dtr_n[1];
  assign rts_a_n = ch_rts_n[0];
  assign rts_b_n = ch_rts_n[1];
  assign irq = irq_ff;

  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  property p_dtr_on;
    wr_ch[0] && aw_ff[4:2] == ua_pkg::UA_R_MCR && wd_ff[0] |=> !dtr_a_n ##1 !dtr_a_n;
  endproperty
  a_dtr_on: assert property (p_dtr_on) else $error("dtr not low after set"); // RL1
  property p_dtr_off;
    wr_ch[0] && aw_ff[4:2] == ua_pkg::UA_R_MCR && !wd_ff[0] |=> dtr_a_n;
  endproperty
  a_dtr_off: assert property (p_dtr_off) else $error("dtr not high after clear"); // RL2
  property p_rts_on;
    wr_ch[1] && aw_ff[4:2] == ua_pkg::UA_R_MCR && wd_ff[1] |=> !rts_b_n && rts_a_n == $past(rts_a_n);
  endproperty
  a_rts_on: assert property (p_rts_on) else $error("rts not low after set"); // RL3
  property p_rts_hold;
    !wr_ch[0] |=> $stable(rts_a_n) && $stable(dtr_a_n);
  endproperty
  a_rts_hold: assert property (p_rts_hold) else $error("handshake moved without write"); // RL4
  property p_ring;
    $rose(ring_in_a_n) |=> stat_ff[0];
  endproperty
  a_ring: assert property (p_ring) else $error("ring edge not flagged"); // RL6
  property p_tx_idle;
    g_ch[0].tst_ff == ua_pkg::UA_IDLE && $past(g_ch[0].tst_ff) == ua_pkg::UA_IDLE |-> serial_out_a;
  endproperty
  a_tx_idle: assert property (p_tx_idle) else $error("serial out low while idle"); // RL7
  property p_loop_rx;
    g_ch[0].mcr_ff[ua_pkg::UA_MCR_LOOP] |-> g_ch[0].rxl == g_ch[0].txd_ff;
  endproperty
  a_loop_rx: assert property (p_loop_rx) else $error("loop data not routed"); // RL9
  property p_loop_pin;
    $past(g_ch[0].mcr_ff[ua_pkg::UA_MCR_LOOP]) |-> serial_out_a;
  endproperty
  a_loop_pin: assert property (p_loop_pin) else $error("pin driven in loop-back"); // RL10
  property p_frame;
    (g_ch[0].tst_ff == ua_pkg::UA_START |-> !g_ch[0].txd_ff)
      and (g_ch[0].tst_ff == ua_pkg::UA_STOP |-> g_ch[0].txd_ff);
  endproperty
  a_frame: assert property (p_frame) else $error("start or stop level wrong"); // RL11
  property p_fifo;
    g_ch[0].tcnt_ff <= (AW+1)'(FIFO_DEPTH) && g_ch[1].rcnt_ff <= (AW+1)'(FIFO_DEPTH);
  endproperty
  a_fifo: assert property (p_fifo) else $error("buffer count overflow"); // RL13
  property p_trig;
    5'(g_ch[0].rcnt_ff) >= g_ch[0].trig_lvl |=> stat_ff[1];
  endproperty
  a_trig: assert property (p_trig) else $error("threshold not flagged"); // RL14
  property p_cs;
    rd_go && s_axi_araddr[7:6] == 2'b01 |=> rvalid_ff && rresp_ff == ua_pkg::UA_RESP_ERR;
  endproperty
  a_cs: assert property (p_cs) else $error("deselected read not refused"); // RL15
  c_tx: cover property (g_ch[0].tst_ff == ua_pkg::UA_STOP ##1 g_ch[0].tst_ff == ua_pkg::UA_IDLE);
  c_rx: cover property (g_ch[1].rpush);
  c_irq: cover property ($rose(irq));
endmodule // ua_top

/* File: testbench/ua_modem_model.sv */
`timescale 1ns/10ps
module ua_modem_model #(
  parameter int BIT_CLKS = 4
)(
  input wire logic clk_sys,
  input wire logic line_in,
  output logic line_out,
  output logic [10:0] frame,
  output logic [7:0] frame_count
);
  logic [10:0] shift;
  // Samples a whole frame from the mid point of its start bit onwards.
  initial
  begin
    line_out = 1'b1;
    frame = 11'h000;
    frame_count = 8'h00;
    forever
    begin
      @(negedge clk_sys);
      if (line_in === 1'b0)
      begin
        repeat (BIT_CLKS / 2) @(negedge clk_sys);
        for (int i = 0; i < 11; i++)
        begin
          shift[i] = line_in;
          repeat (BIT_CLKS) @(negedge clk_sys);
        end
        frame = shift;
        frame_count = frame_count + 8'h01;
      end
    end
  end
  task automatic send_frame(input logic [10:0] bits, input int n);
    for (int i = 0; i < n; i++)
    begin
      @(posedge clk_sys);
      line_out <= bits[i];
      repeat (BIT_CLKS - 1) @(posedge clk_sys);
    end
    @(posedge clk_sys);
    line_out <= 1'b1;
  endtask
endmodule // ua_modem_model

/* File: testbench/testbench.sv */
`timescale 1ns/10ps
module testbench;
  logic clk_sys, sys_rst, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, irq, force_low, model_out;
  logic rx_a, rx_b, ring_a_n, ring_b_n, tx_a, tx_b, dtr_a_n, dtr_b_n, rts_a_n, rts_b_n;
  logic [7:0] awaddr, araddr, frame_count;
  logic [31:0] wdata, rdata, rd;
  logic [1:0] bresp, rresp, last_resp;
  logic [10:0] frame;
  int fail_count = 0;
  int total_checks = 0;
  int cycles = 0;
  assign rx_a = force_low ? 1'b0 : model_out;
  ua_top u_ua_top (.clk_sys(clk_sys), .sys_rst(sys_rst), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .serial_in_a(rx_a), .serial_in_b(rx_b), .ring_in_a_n(ring_a_n), .ring_in_b_n(ring_b_n),
    .serial_out_a(tx_a), .serial_out_b(tx_b), .dtr_a_n(dtr_a_n), .dtr_b_n(dtr_b_n),
    .rts_a_n(rts_a_n), .rts_b_n(rts_b_n), .irq(irq));
  ua_modem_model #(.BIT_CLKS(4)) u_ua_modem_model (.clk_sys(clk_sys), .line_in(tx_a),
    .line_out(model_out), .frame(frame), .frame_count(frame_count));
  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys)
  begin
    cycles = cycles + 1;
    if (cycles == 20000)
    begin
      fail_count = fail_count + 1;
      test_done();
    end
  end
  task test_done();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task check(input string name, input logic [31:0] exp, input logic [31:0] got);
    total_checks = total_checks + 1;
    if (got !== exp)
    begin
      fail_count = fail_count + 1;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask
  // Handshakes are judged at the rising edge itself, before the design's registers move.
  task wr(input logic [7:0] a, input logic [7:0] d);
    logic ta, tw, tb;
    @(posedge clk_sys);
    awaddr <= a;
    wdata <= {24'h000000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    tb = 1'b0;
    while (!tb)
    begin
      @(posedge clk_sys);
      ta = awvalid & awready;
      tw = wvalid & wready;
      tb = bvalid & bready;
      last_resp = bresp;
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      if (tb) bready <= 1'b0;
    end
  endtask
  task rd_reg(input logic [7:0] a);
    logic ta, tr;
    @(posedge clk_sys);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    tr = 1'b0;
    while (!tr)
    begin
      @(posedge clk_sys);
      ta = arvalid & arready;
      tr = rvalid & rready;
      rd = rdata;
      last_resp = rresp;
      if (ta) arvalid <= 1'b0;
      if (tr) rready <= 1'b0;
    end
  endtask
  task tx_capture(input logic [7:0] d);
    logic [7:0] n;
    n = frame_count;
    wr(8'h00, d);
    for (int i = 0; i < 300 && frame_count == n; i++) @(posedge clk_sys);
  endtask
  task test_reset();
    check("pins", 32'h0000007E, {dtr_a_n, dtr_b_n, rts_a_n, rts_b_n, tx_a, tx_b, irq});
    rd_reg(8'h0C);
    check("line ctrl", 32'h00000003, rd);
    $display("reset test done");
  endtask
  task test_modem();
    wr(8'h10, 8'h03);
    check("modem a on", 32'h3, {dtr_a_n, rts_a_n, dtr_b_n, rts_b_n});
    wr(8'h30, 8'h01);
    check("modem b dtr", 32'h1, {dtr_a_n, rts_a_n, dtr_b_n, rts_b_n});
    wr(8'h10, 8'h00);
    wr(8'h30, 8'h00);
    check("modem off", 32'hF, {dtr_a_n, rts_a_n, dtr_b_n, rts_b_n});
    $display("modem test done");
  endtask
  task test_ring();
    wr(8'h84, 8'h00);
    ring_a_n <= 1'b0;
    repeat (4) @(posedge clk_sys);
    ring_a_n <= 1'b1;
    repeat (6) @(posedge clk_sys);
    check("masked irq", 32'h0, irq);
    rd_reg(8'h80);
    check("ring status", 32'h1, rd);
    wr(8'h84, 8'h01);
    repeat (2) @(posedge clk_sys);
    check("irq set", 32'h1, irq);
    wr(8'h80, 8'h01);
    repeat (2) @(posedge clk_sys);
    check("irq clear", 32'h0, irq);
    $display("ring test done");
  endtask
  task test_tx();
    wr(8'h0C, 8'h83);
    wr(8'h00, 8'h04);
    wr(8'h04, 8'h00);
    wr(8'h0C, 8'h03);
    wr(8'h10, 8'h03);
    tx_capture(8'hA5);
    check("tx frame", {22'h0, 1'b1, 8'hA5, 1'b0}, {22'h0, frame[9:0]});
    check("tx idle", 32'h1, tx_a);
    wr(8'h10, 8'h00);
    u_ua_modem_model.send_frame({1'b1, 1'b1, 8'h3C, 1'b0}, 10);
    repeat (8) @(posedge clk_sys);
    rd_reg(8'h14);
    check("rx ready", 32'h1, rd & 32'h1);
    rd_reg(8'h00);
    check("rx data", 32'h3C, rd);
    $display("serial test done");
  endtask
  task test_parity();
    // Seven data bits, odd parity and two stop bits.
    wr(8'h0C, 8'h0E);
    tx_capture(8'h01);
    check("parity frame", {21'h0, 2'b11, 1'b0, 7'h01, 1'b0}, {21'h0, frame});
    u_ua_modem_model.send_frame({1'b1, 1'b1, 1'b1, 7'h01, 1'b0}, 11);
    repeat (8) @(posedge clk_sys);
    rd_reg(8'h14);
    check("parity error", 32'h4, rd & 32'h4);
    rd_reg(8'h00);
    wr(8'h0C, 8'h03);
    $display("parity test done");
  endtask
  task test_loop();
    logic [7:0] n;
    int bad;
    wr(8'h10, 8'h10);
    force_low <= 1'b1;
    n = frame_count;
    bad = 0;
    wr(8'h00, 8'h5A);
    repeat (80)
    begin
      @(negedge clk_sys);
      if (tx_a !== 1'b1) bad = bad + 1;
    end
    check("loop pin high", 32'h0, bad);
    check("loop no frame", {24'h0, n}, {24'h0, frame_count});
    rd_reg(8'h00);
    check("loop data", 32'h5A, rd);
    force_low <= 1'b0;
    wr(8'h10, 8'h00);
    $display("loop test done");
  endtask
  task test_select();
    wr(8'h1C, 8'h77);
    rd_reg(8'h3C);
    check("scratch b", 32'h0, rd);
    rd_reg(8'h1C);
    check("scratch a", 32'h77, rd);
    rd_reg(8'h40);
    check("deselect read", 32'h2, {rd[29:0], last_resp});
    wr(8'h60, 8'h01);
    check("deselect write", 32'h2, last_resp);
    $display("select test done");
  endtask
  initial
  begin
    sys_rst = 1'b1;
    {awvalid, wvalid, bready, arvalid, rready, force_low} = 6'h00;
    {rx_b, ring_a_n, ring_b_n} = 3'h7;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h00000000;
    repeat (4) @(posedge clk_sys);
    sys_rst <= 1'b0;
    @(posedge clk_sys);
    test_reset();
    test_modem();
    test_ring();
    test_tx();
    test_parity();
    test_loop();
    test_select();
    test_done();
  end
endmodule // testbench
